//--- hdl/mcrcfg_regs.vh
// register offsets, field layout, reset values for collision/retry/max-frame config
`ifndef MCRCFG_REGS_VH
`define MCRCFG_REGS_VH

// base register word addresses (byte addresses, aligned words)
`define MCRCFG_ADDR_W          6
`define MCRCFG_OFS_CWRL        6'h00
`define MCRCFG_OFS_CWRL_SET    6'h04
`define MCRCFG_OFS_CWRL_CLR    6'h08
`define MCRCFG_OFS_CWRL_INV    6'h0c
`define MCRCFG_OFS_MAXF        6'h10
`define MCRCFG_OFS_MAXF_SET    6'h14
`define MCRCFG_OFS_MAXF_CLR    6'h18
`define MCRCFG_OFS_MAXF_INV    6'h1c
`define MCRCFG_OFS_IRQ_STAT    6'h20
`define MCRCFG_OFS_IRQ_MASK    6'h24

// alias kind in address bits 3:2
`define MCRCFG_ALIAS_PLAIN     2'h0
`define MCRCFG_ALIAS_SET       2'h1
`define MCRCFG_ALIAS_CLR       2'h2
`define MCRCFG_ALIAS_INV       2'h3

// access size codes
`define MCRCFG_SIZE_8          2'h0
`define MCRCFG_SIZE_16         2'h1
`define MCRCFG_SIZE_32         2'h2

// field layout
`define MCRCFG_SLOT_MSB        13
`define MCRCFG_SLOT_LSB        8
`define MCRCFG_RETRY_MSB       3
`define MCRCFG_RETRY_LSB       0
`define MCRCFG_MAXF_MSB        15
`define MCRCFG_MAXF_LSB        0

// reset values
`define MCRCFG_SLOT_RST        6'h37
`define MCRCFG_RETRY_RST       4'hf
`define MCRCFG_MAXF_RST        16'h05ee

// interrupt status bits
`define MCRCFG_IRQ_W           2
`define MCRCFG_IRQ_XCOL        0
`define MCRCFG_IRQ_OVERLEN     1

`endif

//--- hdl/mcrcfg_top.v
// collision window, retry limit and max frame length configuration registers
// ==========================================================
// Overview of operation
// [R1] collision register bits 31:14 read zero
// [R2] collision register bits 7:4 read zero
// [R3] six-bit slot window at bits 13:8
// [R4] slot window resets to 0x37
// [R5] four-bit retry limit, abandon when exhausted
// [R6] retry limit resets to 0xf
// [R7] sixteen-bit max length resets to 0x05ee
// [R8] max length register bits 31:16 read zero
// [R9] software raises max length for tagged frames
// [R10] 16/32-bit access incl aliases; 8-bit ignored
// [R11] excessive-collision abandon raises status flag
`default_nettype none
`include "mcrcfg_regs.vh"

module mcrcfg_top #(
   parameter ADDR_W = `MCRCFG_ADDR_W
) (
   input  wire              mclk,              // system clock, 50 MHz
   input  wire              rst_n,             // async reset, active low
   input  wire              clk_en,            // freezes all state when low
   input  wire [ADDR_W-1:0] reg_addr,          // byte address
   input  wire [31:0]       reg_wdata,         // write data
   input  wire [1:0]        reg_size,          // 0=8-bit 1=16-bit 2=32-bit
   input  wire              reg_half_sel,      // 16-bit access: 1 selects upper half
   input  wire              reg_wr,            // write strobe
   input  wire              reg_rd,            // read strobe
   output reg  [31:0]       reg_rdata,         // read data, cycle after strobe
   input  wire              tx_collision,      // collision seen during attempt
   input  wire              tx_attempt_done,   // attempt finished without collision
   input  wire [15:0]       rx_frame_len,      // length of frame just received
   input  wire              rx_frame_end,      // receive frame end pulse
   output reg  [5:0]        slot_window_bytes, // collision window in frame bytes
   output reg  [3:0]        retry_attempt_limit, // retransmission limit
   output reg  [15:0]       rx_length_ceiling, // max accepted receive length
   output reg               tx_abandon,        // pulse: packet dropped, excess collisions
   output reg               rx_too_long,       // pulse: frame over ceiling
   output reg               irq                // level interrupt
);

   // ==========================================================
   // registers
   reg [5:0]               slot_ff;
   reg [3:0]               retry_ff;
   reg [15:0]              maxf_ff;
   reg [3:0]               retry_cnt_ff;
   reg [`MCRCFG_IRQ_W-1:0] stat_ff;
   reg [`MCRCFG_IRQ_W-1:0] mask_ff;

   reg [5:0]               nxt_slot;
   reg [3:0]               nxt_retry;
   reg [15:0]              nxt_maxf;
   reg [3:0]               nxt_retry_cnt;
   reg [`MCRCFG_IRQ_W-1:0] nxt_stat;
   reg [`MCRCFG_IRQ_W-1:0] nxt_mask;
   reg                     nxt_abandon;
   reg                     nxt_too_long;
   reg [31:0]              nxt_rdata;

   // ==========================================================
   // access decode
   wire [1:0] alias_kind = reg_addr[3:2];
   wire       sel_cwrl   = (reg_addr[ADDR_W-1:4] == `MCRCFG_OFS_CWRL >> 4) && (reg_addr[1:0] == 2'h0);
   wire       sel_maxf   = (reg_addr[ADDR_W-1:4] == `MCRCFG_OFS_MAXF >> 4) && (reg_addr[1:0] == 2'h0);
   wire       sel_stat   = (reg_addr == `MCRCFG_OFS_IRQ_STAT);
   wire       sel_mask   = (reg_addr == `MCRCFG_OFS_IRQ_MASK);
   // [R10] 8-bit accesses dropped
   wire       size_ok    = (reg_size == `MCRCFG_SIZE_16) || (reg_size == `MCRCFG_SIZE_32);
   wire       wr_ok      = reg_wr && size_ok;

   // [R10] lane mask for 16-bit halves
   wire [31:0] lane_mask = (reg_size == `MCRCFG_SIZE_32) ? 32'hffffffff :
                           (reg_half_sel ? 32'hffff0000 : 32'h0000ffff);
   wire [31:0] wdata_m   = reg_wdata & lane_mask;

   // [R1] [R2] image of collision register, unused bits zero
   wire [31:0] cwrl_img = {18'h00000, slot_ff, 4'h0, retry_ff};
   // [R8] upper half of max length reads zero
   wire [31:0] maxf_img = {16'h0000, maxf_ff};

   function [31:0] apply_alias;
      input [1:0]  kind;
      input [31:0] cur;
      input [31:0] wd;
      input [31:0] lm;
      begin
         case (kind)
            `MCRCFG_ALIAS_SET: apply_alias = cur | wd;
            `MCRCFG_ALIAS_CLR: apply_alias = cur & ~wd;
            `MCRCFG_ALIAS_INV: apply_alias = cur ^ wd;
            default:           apply_alias = (cur & ~lm) | wd;
         endcase
      end
   endfunction

   wire [31:0] cwrl_new = apply_alias(alias_kind, cwrl_img, wdata_m, lane_mask);
   wire [31:0] maxf_new = apply_alias(alias_kind, maxf_img, wdata_m, lane_mask);

   // ==========================================================
   // events
   wire retry_out = tx_collision && (retry_cnt_ff >= retry_ff);
   wire ev_xcol   = retry_out;
   wire ev_long   = rx_frame_end && (rx_frame_len > maxf_ff);

   // ==========================================================
   // next state
   always @* begin
      nxt_slot      = slot_ff;
      nxt_retry     = retry_ff;
      nxt_maxf      = maxf_ff;
      nxt_mask      = mask_ff;
      nxt_retry_cnt = retry_cnt_ff;
      nxt_rdata     = 32'h00000000;
      nxt_abandon   = 1'b0;
      nxt_too_long  = 1'b0;
      // [R3] slot window written at bits 13:8
      if (wr_ok && sel_cwrl) begin
         nxt_slot  = cwrl_new[`MCRCFG_SLOT_MSB:`MCRCFG_SLOT_LSB];
         nxt_retry = cwrl_new[`MCRCFG_RETRY_MSB:`MCRCFG_RETRY_LSB];
      end
      // [R9] ceiling fully programmable
      if (wr_ok && sel_maxf) begin
         nxt_maxf = maxf_new[`MCRCFG_MAXF_MSB:`MCRCFG_MAXF_LSB];
      end
      if (wr_ok && sel_mask) begin
         nxt_mask = wdata_m[`MCRCFG_IRQ_W-1:0];
      end
      // [R5] count retries, abandon on exhaustion
      if (retry_out) begin
         nxt_retry_cnt = 4'h0;
         nxt_abandon   = 1'b1;
      end else if (tx_collision) begin
         nxt_retry_cnt = retry_cnt_ff + 4'h1;
      end else if (tx_attempt_done) begin
         nxt_retry_cnt = 4'h0;
      end
      nxt_too_long = ev_long;
      // [R11] sticky status, set wins over clear
      nxt_stat = stat_ff;
      if (wr_ok && sel_stat) begin
         nxt_stat = stat_ff & ~wdata_m[`MCRCFG_IRQ_W-1:0];
      end
      if (ev_xcol) begin
         nxt_stat[`MCRCFG_IRQ_XCOL] = 1'b1;
      end
      if (ev_long) begin
         nxt_stat[`MCRCFG_IRQ_OVERLEN] = 1'b1;
      end
      // [R10] reads honoured at 16/32 bits only
      if (reg_rd && size_ok) begin
         if (sel_cwrl) begin
            nxt_rdata = cwrl_img & lane_mask;
         end else if (sel_maxf) begin
            nxt_rdata = maxf_img & lane_mask;
         end else if (sel_stat) begin
            nxt_rdata = {30'h00000000, stat_ff} & lane_mask;
         end else if (sel_mask) begin
            nxt_rdata = {30'h00000000, mask_ff} & lane_mask;
         end
      end
   end

   // ==========================================================
   // state
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         // [R4] [R6] [R7] power-on defaults
         slot_ff             <= `MCRCFG_SLOT_RST;
         retry_ff            <= `MCRCFG_RETRY_RST;
         maxf_ff             <= `MCRCFG_MAXF_RST;
         retry_cnt_ff        <= 4'h0;
         stat_ff             <= 2'h0;
         mask_ff             <= 2'h0;
         reg_rdata           <= 32'h00000000;
         slot_window_bytes   <= `MCRCFG_SLOT_RST;
         retry_attempt_limit <= `MCRCFG_RETRY_RST;
         rx_length_ceiling   <= `MCRCFG_MAXF_RST;
         tx_abandon          <= 1'b0;
         rx_too_long         <= 1'b0;
         irq                 <= 1'b0;
      end else if (clk_en) begin
         slot_ff             <= nxt_slot;
         retry_ff            <= nxt_retry;
         maxf_ff             <= nxt_maxf;
         retry_cnt_ff        <= nxt_retry_cnt;
         stat_ff             <= nxt_stat;
         mask_ff             <= nxt_mask;
         reg_rdata           <= nxt_rdata;
         slot_window_bytes   <= nxt_slot;
         retry_attempt_limit <= nxt_retry;
         rx_length_ceiling   <= nxt_maxf;
         tx_abandon          <= nxt_abandon;
         rx_too_long         <= nxt_too_long;
         irq                 <= |(nxt_stat & nxt_mask);
      end
   end

endmodule
`default_nettype wire

//--- verification/mcrcfg_chk_sva.sv
// assertion checker for the config register block
`default_nettype none
module mcrcfg_chk_sva #(
   parameter ADDR_W = 6
) (
   input wire logic              mclk,                // clock
   input wire logic              rst_n,               // reset
   input wire logic              clk_en,              // run enable
   input wire logic [ADDR_W-1:0] reg_addr,            // address
   input wire logic [1:0]        reg_size,            // size code
   input wire logic              reg_wr,              // write strobe
   input wire logic              reg_rd,              // read strobe
   input wire logic [31:0]       reg_rdata,           // read data
   input wire logic [5:0]        slot_window_bytes,   // window
   input wire logic [3:0]        retry_attempt_limit, // limit
   input wire logic [15:0]       rx_length_ceiling    // ceiling
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   logic rd_c;
   logic rd_m;
   assign rd_c = reg_rd && clk_en && reg_size == 2'h2 && reg_addr == 6'h00;
   assign rd_m = reg_rd && clk_en && reg_size == 2'h2 && reg_addr == 6'h10;
   chk_cw_top_zero: assert property (rd_c |=> reg_rdata[31:14] == 18'h0)
      else $error("window register upper bits not zero");
   chk_cw_mid_zero: assert property (rd_c |=> reg_rdata[7:4] == 4'h0)
      else $error("window register middle bits not zero");
   chk_slot_read: assert property (rd_c |=> reg_rdata[13:8] == $past(slot_window_bytes))
      else $error("slot window readback differs");
   chk_retry_read: assert property (rd_c |=> reg_rdata[3:0] == $past(retry_attempt_limit))
      else $error("retry limit readback differs");
   chk_maxf_read: assert property (rd_m |=> reg_rdata == {16'h0, $past(rx_length_ceiling)})
      else $error("max length readback differs");
   chk_byte_write_ignored: assert property (reg_wr && clk_en && reg_size == 2'h0 |=>
      $stable(slot_window_bytes) && $stable(retry_attempt_limit) && $stable(rx_length_ceiling))
      else $error("byte write changed a field");
   chk_reset_defaults: assert property (disable iff (1'b0) !rst_n |-> slot_window_bytes == 6'h37
      && retry_attempt_limit == 4'hf && rx_length_ceiling == 16'h05ee)
      else $error("defaults missing in reset");
   chk_byte_read_zero: assert property (reg_rd && clk_en && reg_size == 2'h0 |=> reg_rdata == 32'h0)
      else $error("byte read returned data");
endmodule
`default_nettype wire

//--- verification/mcrcfg_mac_model.sv
// transmit/receive engine model feeding collision and frame events
`default_nettype none
module mcrcfg_mac_model (
   input  wire logic   mclk,            // clock
   output var logic    tx_collision,    // collision pulse
   output var logic    tx_attempt_done, // attempt ok pulse
   output var logic    rx_frame_end,    // frame end pulse
   output var logic [15:0] rx_frame_len // frame length
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {tx_collision, tx_attempt_done, rx_frame_end, rx_frame_len} = '0;
   task automatic collide(input int n);
      repeat (n) begin
         @(posedge mclk);
         tx_collision <= 1'b1;
         @(posedge mclk);
         tx_collision <= 1'b0;
      end
   endtask
   task automatic attempt_ok;
      @(posedge mclk);
      tx_attempt_done <= 1'b1;
      @(posedge mclk);
      tx_attempt_done <= 1'b0;
   endtask
   task automatic frame(input logic [15:0] len);
      @(posedge mclk);
      rx_frame_len <= len;
      rx_frame_end <= 1'b1;
      @(posedge mclk);
      rx_frame_end <= 1'b0;
      rx_frame_len <= ~len;
   endtask
endmodule
`default_nettype wire

//--- verification/mcrcfg_top_test.sv
// self-checking bench for the config register block
`default_nettype none
module mcrcfg_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rst_n = 1, clk_en = 1, reg_wr = 0, reg_rd = 0, reg_half_sel = 0;
   logic [5:0]  reg_addr = 6'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [1:0]  reg_size = 2'h2;
   wire logic [31:0] reg_rdata;
   wire logic [15:0] rx_frame_len, rx_length_ceiling;
   wire logic [5:0]  slot_window_bytes;
   wire logic [3:0]  retry_attempt_limit;
   wire logic tx_collision, tx_attempt_done, rx_frame_end, tx_abandon, rx_too_long, irq;
   int miscompares = 0, num_checks = 0, n_abandon = 0, n_long = 0;
   always #10 mclk = ~mclk;
   mcrcfg_top u_mcrcfg_top (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_size(reg_size), .reg_half_sel(reg_half_sel), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_collision(tx_collision), .tx_attempt_done(tx_attempt_done),
      .rx_frame_len(rx_frame_len), .rx_frame_end(rx_frame_end), .slot_window_bytes(slot_window_bytes),
      .retry_attempt_limit(retry_attempt_limit), .rx_length_ceiling(rx_length_ceiling),
      .tx_abandon(tx_abandon), .rx_too_long(rx_too_long), .irq(irq));
   mcrcfg_mac_model u_mcrcfg_mac_model (.mclk(mclk), .tx_collision(tx_collision),
      .tx_attempt_done(tx_attempt_done), .rx_frame_end(rx_frame_end), .rx_frame_len(rx_frame_len));
   always @(posedge mclk) if (tx_abandon === 1'b1) n_abandon <= n_abandon + 1;
   always @(posedge mclk) if (rx_too_long === 1'b1) n_long <= n_long + 1;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] s = 2'h2, input logic h = 0);
      @(posedge mclk);
      reg_wr <= 1'b1;
      {reg_addr, reg_wdata, reg_size, reg_half_sel} <= {a, d, s, h};
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] s = 2'h2);
      @(posedge mclk);
      reg_rd <= 1'b1;
      {reg_addr, reg_size, reg_half_sel} <= {a, s, 1'b0};
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, e);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   logic [5:0]  al_a [3] = '{6'h08, 6'h04, 6'h0c};
   logic [31:0] al_d [3] = '{32'h0f00, 32'h0a00, 32'h3f0f};
   logic [31:0] al_e [3] = '{32'h300f, 32'h3a0f, 32'h0500};
   initial begin
      // real falling edge so the async reset acts before the first clock
      rst_n <= 1'b0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      rd(6'h00, 32'h370f);
      rd(6'h10, 32'h05ee);
      wr(6'h00, 32'hffffffff);
      rd(6'h00, 32'h3f0f);
      check(32'(slot_window_bytes), 32'h3f);
      wr(6'h00, 32'h0, 2'h0);
      rd(6'h00, 32'h3f0f);
      rd(6'h00, 32'h0, 2'h0);
      wr(6'h10, 32'hffff0000, 2'h1, 1'b1);
      wr(6'h10, 32'h05f2, 2'h1);
      rd(6'h10, 32'h05f2);
      for (int i = 0; i < 3; i++) begin
         wr(al_a[i], al_d[i]);
         rd(6'h00, al_e[i]);
      end
      $display("register tests done");
      rd(6'h3c, 32'h0);
      wr(6'h00, 32'h3702);
      wr(6'h24, 32'h1);
      u_mcrcfg_mac_model.collide(2);
      u_mcrcfg_mac_model.attempt_ok();
      u_mcrcfg_mac_model.collide(2);
      repeat (3) @(posedge mclk);
      #1 check(n_abandon, 0);
      u_mcrcfg_mac_model.collide(1);
      repeat (4) @(posedge mclk);
      #1 check(n_abandon, 1);
      check(32'(irq), 1);
      rd(6'h20, 32'h1);
      wr(6'h20, 32'h1);
      repeat (2) @(posedge mclk);
      #1 check(32'(irq), 0);
      u_mcrcfg_mac_model.frame(16'd1522);
      rd(6'h20, 32'h0);
      check(n_long, 0);
      u_mcrcfg_mac_model.frame(16'd1523);
      rd(6'h20, 32'h2);
      check(n_long, 1);
      $display("event tests done");
      results();
   end
endmodule
bind mcrcfg_top mcrcfg_chk_sva #(.ADDR_W(ADDR_W)) u_mcrcfg_chk_sva (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
   .reg_addr(reg_addr), .reg_size(reg_size), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .slot_window_bytes(slot_window_bytes), .retry_attempt_limit(retry_attempt_limit),
   .rx_length_ceiling(rx_length_ceiling));
`default_nettype wire
